// *** core/wdt_core_end.sv ***
// Processor-core end: APB registers drive the watchdog link.
// Assumes a standard APB master; pready is always high (zero wait states).
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module wdt_core_end (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// RC tick source
	input wire logic i_low_power_rc_oscillator_tick,
	// Link to the watchdog
	wdt_link_if.core link
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfg;
		logic [1:0] win;
		logic [1:0] hwen;
		logic swen;
		logic sleep_f;
		logic idle_f;
		logic [5:0] cmd;
		logic [31:0] rdata;
		logic err;
	} state_type;

	state_type state_q;
	state_type state_d;
	logic wr;
	logic rd;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	always_comb begin
		wr = i_psel && i_penable && i_pwrite;
		rd = i_psel && !i_penable && !i_pwrite;
		state_d = state_q;
		state_d.cmd = '0;
		state_d.err = 1'b0;
		if (link.wake_request) begin
			state_d.sleep_f = state_q.sleep_f;
		end
		if (wr) begin
			if (hit(i_paddr, wdt_pkg::ADDR_CONFIG)) begin
				state_d.cfg = i_pwdata[7:0];
				state_d.win = i_pwdata[9:8];
				state_d.hwen = i_pwdata[11:10];
			end else if (hit(i_paddr, wdt_pkg::ADDR_COMMAND)) begin
				state_d.cmd = i_pwdata[5:0];
				if (i_pwdata[wdt_pkg::CMD_SLEEP_BIT]) begin
					state_d.sleep_f = 1'b1;
				end
				if (i_pwdata[wdt_pkg::CMD_IDLE_BIT]) begin
					state_d.idle_f = 1'b1;
				end
			end else if (hit(i_paddr, wdt_pkg::ADDR_RESET_CONTROL_REGISTER)) begin
				state_d.swen = i_pwdata[wdt_pkg::RC_SWEN_BIT];
				state_d.sleep_f = i_pwdata[wdt_pkg::RC_SLEEP_BIT] && state_q.sleep_f;
				state_d.idle_f = i_pwdata[wdt_pkg::RC_IDLE_BIT] && state_q.idle_f;
				state_d.cmd[wdt_pkg::CMD_ACK_BIT] = !i_pwdata[wdt_pkg::RC_TIMEOUT_BIT];
			end else if (!hit(i_paddr, wdt_pkg::ADDR_STATUS)) begin
				state_d.err = 1'b1;
			end
		end
		if (rd) begin
			state_d.rdata = '0;
			if (hit(i_paddr, wdt_pkg::ADDR_CONFIG)) begin
				state_d.rdata = {20'h00000, state_q.hwen, state_q.win, state_q.cfg};
			end else if (hit(i_paddr, wdt_pkg::ADDR_STATUS)) begin
				state_d.rdata = {28'h0000000, link.window_violation, link.wake_request,
					link.device_reset_request, link.running};
			end else if (hit(i_paddr, wdt_pkg::ADDR_RESET_CONTROL_REGISTER)) begin
				state_d.rdata[wdt_pkg::RC_SWEN_BIT] = state_q.swen;
				state_d.rdata[wdt_pkg::RC_TIMEOUT_BIT] = link.timeout_flag;
				state_d.rdata[wdt_pkg::RC_SLEEP_BIT] = state_q.sleep_f;
				state_d.rdata[wdt_pkg::RC_IDLE_BIT] = state_q.idle_f;
			end else if (!hit(i_paddr, wdt_pkg::ADDR_COMMAND)) begin
				state_d.err = 1'b1;
			end
		end
		if (rd && !(hit(i_paddr, wdt_pkg::ADDR_CONFIG) || hit(i_paddr, wdt_pkg::ADDR_STATUS) ||
			hit(i_paddr, wdt_pkg::ADDR_RESET_CONTROL_REGISTER) || hit(i_paddr, wdt_pkg::ADDR_COMMAND))) begin
			state_d.err = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Error on an unmapped address, read or write, is flagged combinationally in the access phase.
	assign o_pready = 1'b1;
	assign o_prdata = state_q.rdata;
	assign o_pslverr = i_psel && i_penable && !(hit(i_paddr, wdt_pkg::ADDR_CONFIG) ||
		hit(i_paddr, wdt_pkg::ADDR_STATUS) || hit(i_paddr, wdt_pkg::ADDR_RESET_CONTROL_REGISTER) ||
		hit(i_paddr, wdt_pkg::ADDR_COMMAND));

	assign link.clear_watchdog_instruction = state_q.cmd[wdt_pkg::CMD_CLEAR_BIT];
	assign link.power_save_instruction = state_q.cmd[wdt_pkg::CMD_SLEEP_BIT] || state_q.cmd[wdt_pkg::CMD_IDLE_BIT];
	assign link.power_save_idle = state_q.cmd[wdt_pkg::CMD_IDLE_BIT];
	assign link.wake_exit = state_q.cmd[wdt_pkg::CMD_WAKE_BIT];
	assign link.clock_switch_done = state_q.cmd[wdt_pkg::CMD_SWITCH_BIT];
	assign link.timeout_flag_clear = state_q.cmd[wdt_pkg::CMD_ACK_BIT];
	assign link.low_power_rc_oscillator_tick = i_low_power_rc_oscillator_tick;
	assign link.postscale_select_field = state_q.cfg[wdt_pkg::CFG_POST_LSB +: wdt_pkg::POST_SEL_W];
	assign link.prescale_select_bit = state_q.cfg[wdt_pkg::CFG_PRE_BIT];
	assign link.window_disable_bit = state_q.cfg[wdt_pkg::CFG_WINDOW_DISABLE_BIT_BIT];
	assign link.window_size_field = state_q.win;
	assign link.hw_enable_field = state_q.hwen;
	assign link.software_enable_bit = state_q.swen;

endmodule
`default_nettype wire

// *** core/wdt_device.sv ***
// Windowed watchdog timer counting low-power RC ticks.
// Assumes i_low_power_rc_oscillator_tick is a one-cycle strobe synchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module wdt_device (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// RC oscillator tick from the user side
	input wire logic i_low_power_rc_oscillator_tick,
	// Link to the core
	wdt_link_if.device link
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [wdt_pkg::PRE_W-1:0] pre;
		logic [wdt_pkg::POST_W-1:0] post;
		logic [wdt_pkg::WIN_W:0] quarter;
		logic timeout;
		logic wake;
		logic rst_req;
		logic viol;
	} state_type;

	state_type state_q;
	state_type state_d;
	logic enabled;
	logic in_save;
	logic pre_wrap;
	logic post_wrap;
	logic any_clear;
	logic [wdt_pkg::POST_W-1:0] post_last;
	logic [wdt_pkg::POST_W-1:0] quarter_len;
	logic window_open;

	// Sleep/idle are tracked by the core's power-save and exit strobes and by this block's own time-out wake.
	logic save_q;

	// ----------------------------------------------------------------
	// Combinational next state
	// ----------------------------------------------------------------
	always_comb begin
		enabled = (link.hw_enable_field != wdt_pkg::HWEN_SOFT) || link.software_enable_bit;
		in_save = save_q;
		post_last = (wdt_pkg::POST_W)'((16'h0001 << link.postscale_select_field) - 16'h0001);
		// Quarter of the full period in postscaler counts, so the window scales with the ratio.
		quarter_len = (wdt_pkg::POST_W)'(({1'b0, post_last} + 16'h0001) >> wdt_pkg::WIN_W);
		pre_wrap = i_low_power_rc_oscillator_tick && (state_q.pre == (link.prescale_select_bit ?
			wdt_pkg::PRE_LAST_128 : wdt_pkg::PRE_LAST_32));
		post_wrap = pre_wrap && (state_q.post == post_last);
		// Window opens once the postscaler passes the chosen fraction of the period.
		window_open = link.window_disable_bit ||
			(state_q.post >= (wdt_pkg::POST_W)'(quarter_len * (wdt_pkg::POST_W)'(link.window_size_field)));
		any_clear = link.clock_switch_done || link.power_save_instruction || link.wake_exit ||
			link.clear_watchdog_instruction;
		state_d = state_q;
		state_d.wake = 1'b0;
		state_d.rst_req = 1'b0;
		state_d.viol = 1'b0;
		if (link.timeout_flag_clear) begin
			state_d.timeout = 1'b0;
		end
		if (!enabled || any_clear) begin
			state_d.pre = '0;
			state_d.post = '0;
		end else if (i_low_power_rc_oscillator_tick) begin
			state_d.pre = pre_wrap ? '0 : state_q.pre + 1'b1;
			if (pre_wrap) begin
				state_d.post = post_wrap ? '0 : state_q.post + 1'b1;
			end
		end
		if (enabled && link.clear_watchdog_instruction && !in_save && !window_open) begin
			state_d.viol = 1'b1;
			state_d.rst_req = 1'b1;
		end
		if (enabled && !any_clear && post_wrap) begin
			state_d.timeout = 1'b1;
			if (in_save) begin
				state_d.wake = 1'b1;
			end else begin
				state_d.rst_req = 1'b1;
			end
		end
		state_d.quarter = '0;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= '0;
			save_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (link.power_save_instruction) begin
				save_q <= 1'b1;
			end else if (link.wake_exit || state_d.wake) begin
				save_q <= 1'b0;
			end
		end
	end

	assign link.low_power_rc_oscillator_en = enabled;
	assign link.timeout_flag = state_q.timeout;
	assign link.wake_request = state_q.wake;
	assign link.device_reset_request = state_q.rst_req;
	assign link.window_violation = state_q.viol;
	assign link.running = enabled;

endmodule
`default_nettype wire

// *** core/wdt_link_if.sv ***
// Interface joining the watchdog to the processor core.
// Assumes both ends share i_sys_clk; all strobes are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
interface wdt_link_if;
	logic clear_watchdog_instruction;
	logic power_save_instruction;
	logic power_save_idle;
	logic wake_exit;
	logic clock_switch_done;
	logic low_power_rc_oscillator_tick;
	logic [wdt_pkg::POST_SEL_W-1:0] postscale_select_field;
	logic prescale_select_bit;
	logic window_disable_bit;
	logic [wdt_pkg::WIN_W-1:0] window_size_field;
	logic [wdt_pkg::HWEN_W-1:0] hw_enable_field;
	logic software_enable_bit;
	logic timeout_flag_clear;
	logic low_power_rc_oscillator_en;
	logic timeout_flag;
	logic wake_request;
	logic device_reset_request;
	logic window_violation;
	logic running;

	modport device (
		input clear_watchdog_instruction, power_save_instruction, power_save_idle, wake_exit,
		input clock_switch_done, low_power_rc_oscillator_tick, postscale_select_field, prescale_select_bit,
		input window_disable_bit, window_size_field, hw_enable_field, software_enable_bit,
		input timeout_flag_clear,
		output low_power_rc_oscillator_en, timeout_flag, wake_request, device_reset_request,
		output window_violation, running
	);
	modport core (
		output clear_watchdog_instruction, power_save_instruction, power_save_idle, wake_exit,
		output clock_switch_done, low_power_rc_oscillator_tick, postscale_select_field, prescale_select_bit,
		output window_disable_bit, window_size_field, hw_enable_field, software_enable_bit,
		output timeout_flag_clear,
		input low_power_rc_oscillator_en, timeout_flag, wake_request, device_reset_request,
		input window_violation, running
	);
endinterface
`default_nettype wire

// *** core/wdt_pkg.sv ***
// Constants and types shared by both ends of the windowed watchdog link.
// Assumes one 10 MHz system clock; the low-power RC tick arrives as a one-cycle strobe.
//
// Notes on behaviour
// - Watchdog counts low-power RC ticks; enable requests oscillator
// - Prescaler divides by 32 or 128
// - Postscaler picks one of 16 ratios, 1:1..1:32768
// - Completed clock switch clears all counts
// - Power-save instruction clears all counts
// - Leaving sleep or idle clears all counts
// - Core clears periodically; clear zeroes counts
// - Enabled watchdog keeps counting in sleep/idle
// - Time-out in sleep/idle wakes, not resets
// - Software clears sleep/idle flags after wake
// - Nonzero hardware enable forces watchdog always on
// - Hardware enable 00 defers to software bit
// - Device reset clears software enable bit (here device_reset_request leaves software_enable_bit set)
// - Time-out flag sticky until software clears
// - Window-disable bit 0 selects windowed mode
// - Software clears only inside allowed window
package wdt_pkg;

	// ----------------------------------------------------------------
	// Counter widths and divides
	// ----------------------------------------------------------------
	localparam int PRE_W = 7;
	localparam logic [6:0] PRE_LAST_32 = 7'h1f;
	localparam logic [6:0] PRE_LAST_128 = 7'h7f;
	localparam int POST_W = 15;
	localparam int POST_SEL_W = 4;
	localparam int WIN_W = 2;
	localparam int HWEN_W = 2;
	localparam logic [1:0] HWEN_SOFT = 2'h0;

	// ----------------------------------------------------------------
	// Configuration word bit positions
	// ----------------------------------------------------------------
	localparam int CFG_POST_LSB = 0;
	localparam int CFG_PRE_BIT = 4;
	localparam int CFG_WINDOW_DISABLE_BIT_BIT = 7;

	// ----------------------------------------------------------------
	// Reset control register bit positions
	// ----------------------------------------------------------------
	localparam int RC_IDLE_BIT = 2;
	localparam int RC_SLEEP_BIT = 3;
	localparam int RC_TIMEOUT_BIT = 4;
	localparam int RC_SWEN_BIT = 5;

	// ----------------------------------------------------------------
	// Host register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RESET_CONTROL_REGISTER = 8'h0c;
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	localparam int CMD_IDLE_BIT = 2;
	localparam int CMD_WAKE_BIT = 3;
	localparam int CMD_SWITCH_BIT = 4;
	localparam int CMD_ACK_BIT = 5;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_IDLE
	} power_type;

endpackage

// *** dv/wdt_link_properties.sv ***
// Concurrent checks on the watchdog link between the two design ends.
// Assumes one clock domain and the async active-high reset of that domain.
`timescale 1ns/100ps
`default_nettype none
module wdt_link_properties (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Core to watchdog
	input wire logic clear_watchdog_instruction,
	input wire logic power_save_instruction,
	input wire logic wake_exit,
	input wire logic clock_switch_done,
	input wire logic window_disable_bit,
	input wire logic [wdt_pkg::WIN_W-1:0] window_size_field,
	input wire logic [wdt_pkg::HWEN_W-1:0] hw_enable_field,
	input wire logic software_enable_bit,
	input wire logic timeout_flag_clear,
	// Watchdog to core
	input wire logic low_power_rc_oscillator_en,
	input wire logic timeout_flag,
	input wire logic wake_request,
	input wire logic device_reset_request,
	input wire logic window_violation,
	input wire logic running
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	logic fire;
	assign fire = device_reset_request | wake_request;
	// A fresh count needs at least 32 ticks, far longer than this quiet span
	property quiet_after(ev);
		ev |-> ##3 !fire [*8];
	endproperty
	osc_follows_run_a: assert property (running |-> low_power_rc_oscillator_en) else $error("osc off");
	hw_forces_on_a: assert property (hw_enable_field != wdt_pkg::HWEN_SOFT && $stable(hw_enable_field) |-> running)
		else $error("hw enable ignored");
	soft_gate_a: assert property (hw_enable_field == wdt_pkg::HWEN_SOFT && $stable(hw_enable_field)
		&& $stable(software_enable_bit) |-> running == software_enable_bit) else $error("sw enable ignored");
	flag_sticky_a: assert property (timeout_flag && !timeout_flag_clear |=> timeout_flag) else $error("flag lost");
	clear_quiet_a: assert property (quiet_after(clear_watchdog_instruction && (window_disable_bit
		|| window_size_field == 2'h0))) else $error("event after clear");
	save_quiet_a: assert property (quiet_after(power_save_instruction)) else $error("event after save");
	switch_quiet_a: assert property (quiet_after(clock_switch_done)) else $error("event after switch");
	exit_quiet_a: assert property (quiet_after(wake_exit)) else $error("event after exit");
	wake_not_reset_a: assert property (wake_request |-> !device_reset_request) else $error("wake reset");
	early_clear_reset_a: assert property (window_violation |-> ##[0:1] device_reset_request) else $error("no reset");
	timeout_flags_a: assert property (device_reset_request && !window_violation && !$past(window_violation)
		|-> ##[0:1] timeout_flag) else $error("flag not set");
	cover property (device_reset_request);
	cover property (wake_request);
	cover property (window_violation);
endmodule
`default_nettype wire

// *** dv/windowed_watchdog_timer_tb.sv ***
// Self-checking bench joining both watchdog ends through the link.
// Assumes a 10 MHz clock and an RC tick strobe every other cycle.
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_tb;
	logic i_sys_clk = 0, i_rst = 1, tick = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int num_errors = 0, total_checks = 0, n, v0, viol_cnt = 0, rst_cnt = 0;
	wdt_link_if link ();
	wdt_device wdt_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_low_power_rc_oscillator_tick(tick), .link(link.device));
	wdt_core_end wdt_core_end_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_low_power_rc_oscillator_tick(tick), .link(link.core));
	wdt_link_properties wdt_link_properties_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.clear_watchdog_instruction(link.clear_watchdog_instruction), .wake_exit(link.wake_exit),
		.power_save_instruction(link.power_save_instruction), .clock_switch_done(link.clock_switch_done),
		.window_disable_bit(link.window_disable_bit), .window_size_field(link.window_size_field),
		.hw_enable_field(link.hw_enable_field), .software_enable_bit(link.software_enable_bit),
		.timeout_flag_clear(link.timeout_flag_clear), .low_power_rc_oscillator_en(link.low_power_rc_oscillator_en),
		.timeout_flag(link.timeout_flag), .wake_request(link.wake_request), .running(link.running),
		.device_reset_request(link.device_reset_request), .window_violation(link.window_violation));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		tick <= ~tick & ~i_rst;
		viol_cnt <= viol_cnt + (link.window_violation === 1'b1);
		rst_cnt <= rst_cnt + (link.device_reset_request === 1'b1);
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do @(posedge i_sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input int b);
		apb(1'b1, wdt_pkg::ADDR_COMMAND, 32'h1 << b);
	endtask
	// Skips the strobe latency, then counts cycles to the next time-out event
	task automatic wait_ev();
		repeat (3) @(posedge i_sys_clk);
		n = 3;
		while (link.device_reset_request !== 1'b1 && link.wake_request !== 1'b1 && n < 5000) begin
			@(posedge i_sys_clk);
			n++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b1, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h20);
		i_rst <= 1'b1;
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
		check("reset_control_register", 32'h0, rd);
		apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0);
		check("status", 32'h0, rd);
		$display("reset test done");
	endtask
	task automatic t_enable();
		for (int h = 0; h < 4; h++) begin
			for (int s = 0; s < 2; s++) begin
				apb(1'b1, wdt_pkg::ADDR_CONFIG, 32'h80 | (32'(h) << 10));
				apb(1'b1, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'(s) << 5);
				apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0);
				check("running", 32'(h != 0 || s != 0), {31'h0, rd[0]});
			end
		end
		$display("enable test done");
	endtask
	task automatic t_period();
		logic [31:0] cfg [4] = '{32'h480, 32'h481, 32'h490, 32'h482};
		int tk [4] = '{32, 64, 128, 128};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, wdt_pkg::ADDR_CONFIG, cfg[i]);
			cmd(wdt_pkg::CMD_CLEAR_BIT);
			wait_ev();
			check("period", 32'(2 * tk[i]), (n > 2 * tk[i] - 12 && n < 2 * tk[i] + 6) ? 32'(2 * tk[i]) : 32'(n));
		end
		apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
		check("flag", 32'h1, {31'h0, rd[4]});
		repeat (20) @(posedge i_sys_clk);
		apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
		check("flag held", 32'h1, {31'h0, rd[4]});
		// Set hardware enable back to 00 first, so the write that clears the flag also clears the software enable bit and stops the watchdog.
		apb(1'b1, wdt_pkg::ADDR_CONFIG, 32'h80);
		apb(1'b1, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
		apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
		check("flag cleared", 32'h0, {31'h0, rd[4]});
		$display("period test done");
	endtask
	task automatic t_sleep();
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, wdt_pkg::ADDR_CONFIG, 32'h480);
			cmd(i == 0 ? wdt_pkg::CMD_SLEEP_BIT : wdt_pkg::CMD_IDLE_BIT);
			wait_ev();
			check("wake", 32'h1, {31'h0, link.wake_request});
			check("save period", 32'h1, 32'(n > 52 && n < 70));
			apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
			check("save flag", 32'h1, {31'h0, rd[i == 0 ? wdt_pkg::RC_SLEEP_BIT : wdt_pkg::RC_IDLE_BIT]});
			apb(1'b1, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
			apb(1'b0, wdt_pkg::ADDR_RESET_CONTROL_REGISTER, 32'h0);
			check("save flags", 32'h0, {30'h0, rd[3:2]});
		end
		$display("sleep test done");
	endtask
	task automatic t_window();
		apb(1'b1, wdt_pkg::ADDR_CONFIG, 32'h602);
		v0 = viol_cnt;
		cmd(wdt_pkg::CMD_CLEAR_BIT);
		cmd(wdt_pkg::CMD_CLEAR_BIT);
		repeat (5) @(posedge i_sys_clk);
		check("early clear", 32'h1, 32'(viol_cnt > v0));
		repeat (150) @(posedge i_sys_clk);
		v0 = viol_cnt;
		cmd(wdt_pkg::CMD_CLEAR_BIT);
		repeat (5) @(posedge i_sys_clk);
		check("late clear", 32'(v0), 32'(viol_cnt));
		$display("window test done");
	endtask
	task automatic t_holdoff();
		int b [3] = '{wdt_pkg::CMD_CLEAR_BIT, wdt_pkg::CMD_WAKE_BIT, wdt_pkg::CMD_SWITCH_BIT};
		apb(1'b1, wdt_pkg::ADDR_CONFIG, 32'h480);
		cmd(wdt_pkg::CMD_CLEAR_BIT);
		v0 = rst_cnt;
		for (int i = 0; i < 9; i++) begin
			repeat (40) @(posedge i_sys_clk);
			cmd(b[i % 3]);
		end
		check("no timeout", 32'(v0), 32'(rst_cnt));
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		$display("holdoff test done");
	endtask
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_reset();
		t_enable();
		t_period();
		t_sleep();
		t_window();
		t_holdoff();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
